// >>> core/aes_defines.svh
/*
  Constants of the alarm event status block: register offsets, field
  positions, reset values and limits. Assumes inclusion by bare name from
  the package and the design modules; holds definitions only.

*/
`ifndef AES_DEFINES_SVH
`define AES_DEFINES_SVH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define AES_NUM_EVT    14
`define AES_LIST_ROWS  4'h7
`define AES_PQ_MAX     8'hFA

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define AES_REG_STATUS 8'h00
`define AES_REG_COUNT  8'h04
`define AES_REG_LATCH  8'h08
`define AES_REG_ENABLE 8'h0C
`define AES_REG_CTRL   8'h10
`define AES_REG_IRQST  8'h14
`define AES_REG_IRQMSK 8'h18
`define AES_REG_QUEUE  8'h1C
`define AES_REG_SCROLL 8'h20

// ------------------------------------------------------------
// control fields and interrupt bits
// ------------------------------------------------------------
`define AES_CTRL_CLEAR  0
`define AES_CTRL_ACCEPT 1
`define AES_CTRL_TGLLAT 2
`define AES_CTRL_TGLEN  3
`define AES_CTRL_IDX_LO 8
`define AES_IRQ_NEWEVT  0
`define AES_IRQ_CLRDONE 1
`define AES_IRQ_SAVED   2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define AES_LATCH_RST  14'h0001
`define AES_ENABLE_RST 14'h0001
`define AES_IRQMSK_RST 3'h0

`endif

// >>> core/aes_pkg.sv
/*
  Types shared by the alarm event status modules. Assumes the defines
  header is on the include path.
*/
`include "aes_defines.svh"

package aes_pkg;

  typedef logic [`AES_NUM_EVT-1:0] aes_evt_t;

  // keypad strobes, one cycle each
  typedef struct packed {
    logic scrollUp;
    logic scrollDown;
    logic accept;
    logic clear;
  } aes_keys_t;

  // mask pair as stored in nonvolatile memory
  typedef struct packed {
    aes_evt_t latchMask;
    aes_evt_t enMask;
  } aes_nv_t;

  typedef enum logic [2:0] {
    CLR_IDLE = 3'b001,
    CLR_WIPE = 3'b010,
    CLR_ACK  = 3'b100
  } aes_clr_t;

  // number of set bits in an event vector
  function automatic logic [3:0] aes_popcnt(input aes_evt_t v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < `AES_NUM_EVT; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction : aes_popcnt

endpackage : aes_pkg

// >>> core/aes_counter.sv
/*
  Active event counter: registers the number of set status bits.
  Assumes a registered status vector at its input.
*/
`include "aes_defines.svh"

module aes_counter
  import aes_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire aes_evt_t   status,
  output logic      [3:0] count_q
);

  // one flop stage keeps the adder tree off the read path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= 4'h0;
    end else begin
      count_q <= aes_popcnt(status);
    end
  end

  chk_count_track: assert property (@(posedge clk) disable iff (!resetn)
    ##1 count_q == aes_popcnt($past(status)))
    else $error("active count does not match status");

endmodule : aes_counter

// >>> core/aes_scroller.sv
/*
  Event list scroller: keeps the first visible row of a seven-row list.
  Assumes one-cycle key strobes and a count that changes at any time.
*/
`include "aes_defines.svh"

module aes_scroller
  import aes_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] count,
  input  wire logic       up,
  input  wire logic       down,
  output logic      [3:0] pos_q,
  output logic            scrollable_q
);

  logic [3:0] maxPos;
  logic       more;
  logic [3:0] pos_d;

  // last legal first row; shrinking the list pulls the window back
  assign more   = count > `AES_LIST_ROWS;
  assign maxPos = more ? 4'(count - `AES_LIST_ROWS) : 4'h0;
  assign pos_d  = (pos_q > maxPos)         ? maxPos :
                  (down && pos_q < maxPos) ? 4'(pos_q + 4'h1) :
                  (up && pos_q != 4'h0)    ? 4'(pos_q - 4'h1) : pos_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_q        <= 4'h0;
      scrollable_q <= 1'b0;
    end else begin
      pos_q        <= pos_d;
      scrollable_q <= more;
    end
  end

  chk_scroll_reach: assert property (@(posedge clk) disable iff (!resetn)
    $past(more) && $past(down) && $past(pos_q) < $past(maxPos) |-> pos_q == $past(pos_q) + 4'h1)
    else $error("scroll down did not advance");

  cov_scroll: cover property (@(posedge clk) disable iff (!resetn) more && down);

endmodule : aes_scroller

// >>> core/aes_event_status.sv
/*
  Alarm event status block: fourteen event bits with enable and latch masks,
  clear sequence, active count, list scroller, nonvolatile save port,
  pulse queue readout and an interrupt.
  Assumes event conditions, keypad strobes and the register port are
  synchronous to clk; the nonvolatile memory accepts a one-cycle save
  strobe and may reload masks with a one-cycle load strobe after power-up.
*/
// The address map and the plain strobed port were chosen for this implementation.
`include "aes_defines.svh"

module aes_event_status
  import aes_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [31:0] rdData_q,
  input  wire aes_evt_t    evtCond,
  input  wire aes_keys_t   keys,
  input  wire logic [7:0]  pulseQueueOccupancy,
  input  wire logic        nvLoadStb,
  input  wire aes_nv_t     nvLoadData,
  output logic             nvWrStb_q,
  output aes_nv_t          nvWrData_q,
  output aes_evt_t         status_q,
  output logic      [3:0]  count_q,
  output logic             clrAck_q,
  output logic      [3:0]  scrollPos_q,
  output logic             scrollable_q,
  output logic             irq_q
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  aes_evt_t   latchMask_q;
  aes_evt_t   latchMask_d;
  aes_evt_t   enMask_q;
  aes_evt_t   enMask_d;
  aes_evt_t   sticky_q;
  aes_evt_t   sticky_d;
  aes_evt_t   status_d;
  aes_clr_t   clrState_q;
  aes_clr_t   clrState_d;
  logic [2:0] irqSt_q;
  logic [2:0] irqSt_d;
  logic [2:0] irqMask_q;
  logic [31:0] rdMux;

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  logic     wrLatch;
  logic     wrEnable;
  logic     wrCtrl;
  logic     wrIrqMask;
  logic     rdIrqSt;
  logic     clearReq;
  logic     acceptEv;
  logic     tglLatch;
  logic     tglEn;
  aes_evt_t tglSel;
  logic [3:0] tglIdx;

  assign wrLatch   = wrStb && addr == `AES_REG_LATCH;
  assign wrEnable  = wrStb && addr == `AES_REG_ENABLE;
  assign wrCtrl    = wrStb && addr == `AES_REG_CTRL;
  assign wrIrqMask = wrStb && addr == `AES_REG_IRQMSK;
  assign rdIrqSt   = rdStb && addr == `AES_REG_IRQST;

  // keypad and host share the clear and accept commands
  assign clearReq = keys.clear || (wrCtrl && wrData[`AES_CTRL_CLEAR]);
  assign acceptEv = keys.accept || (wrCtrl && wrData[`AES_CTRL_ACCEPT]);
  assign tglLatch = wrCtrl && wrData[`AES_CTRL_TGLLAT];
  assign tglEn    = wrCtrl && wrData[`AES_CTRL_TGLEN];
  assign tglIdx   = wrData[`AES_CTRL_IDX_LO +: 4];

  // index beyond D selects nothing, so a bad toggle changes no bit
  assign tglSel = (tglIdx < 4'(`AES_NUM_EVT)) ? aes_evt_t'(1) << tglIdx : '0;

  // ------------------------------------------------------------
  // masks
  // ------------------------------------------------------------
  // a set bit enables the feature; toggles flip one bit; a whole-word
  // write beats a toggle in the same cycle, the nv reload beats both
  assign latchMask_d = nvLoadStb ? nvLoadData.latchMask :
                       wrLatch   ? wrData[`AES_NUM_EVT-1:0] :
                       tglLatch  ? latchMask_q ^ tglSel :
                                   latchMask_q;
  assign enMask_d    = nvLoadStb ? nvLoadData.enMask :
                       wrEnable  ? wrData[`AES_NUM_EVT-1:0] :
                       tglEn     ? enMask_q ^ tglSel :
                                   enMask_q;

  // masks are not touched by the clear sequence, only by reset defaults, whole-word writes, toggles and the nv reload
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latchMask_q <= `AES_LATCH_RST;
      enMask_q    <= `AES_ENABLE_RST;
    end else begin
      latchMask_q <= latchMask_d;
      enMask_q    <= enMask_d;
    end
  end

  // ------------------------------------------------------------
  // event status
  // ------------------------------------------------------------
  // sticky bits catch enabled, latched events; a condition present in
  // the wipe cycle survives, so no event is lost to the clear
  assign sticky_d = ((clrState_q == CLR_WIPE ? '0 : sticky_q)
                    | (evtCond & latchMask_q & enMask_q))
                    & latchMask_q & enMask_q;

  // disabled events never show; unlatched events follow the condition
  assign status_d = enMask_q & (evtCond | (sticky_d & latchMask_q));

  // status lives in volatile flops and comes up empty
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sticky_q <= '0;
      status_q <= '0;
    end else begin
      sticky_q <= sticky_d;
      status_q <= status_d;
    end
  end

  // ------------------------------------------------------------
  // clear sequence
  // ------------------------------------------------------------
  // wipe first, acknowledge one cycle later; requests during the
  // sequence are dropped since the wipe already covers them
  always_comb begin
    clrState_d = clrState_q;
    case (clrState_q)
      CLR_IDLE: begin
        if (clearReq) begin
          clrState_d = CLR_WIPE;
        end
      end
      CLR_WIPE: begin
        clrState_d = CLR_ACK;
      end
      CLR_ACK: begin
        clrState_d = CLR_IDLE;
      end
      default: begin
        clrState_d = CLR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clrState_q <= CLR_IDLE;
      clrAck_q   <= 1'b0;
    end else begin
      clrState_q <= clrState_d;
      clrAck_q   <= clrState_q == CLR_WIPE;
    end
  end

  // ------------------------------------------------------------
  // nonvolatile save
  // ------------------------------------------------------------
  // the saved image carries the masks as they stand after this cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvWrStb_q  <= 1'b0;
      nvWrData_q <= '0;
    end else begin
      nvWrStb_q <= acceptEv;
      if (acceptEv) begin
        nvWrData_q <= '{latchMask: latchMask_d, enMask: enMask_d};
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  logic [2:0] irqEv;

  assign irqEv[`AES_IRQ_NEWEVT]  = |(status_d & ~status_q);
  assign irqEv[`AES_IRQ_CLRDONE] = clrState_q == CLR_WIPE;
  assign irqEv[`AES_IRQ_SAVED]   = acceptEv;
  // a read clears, but an event in the same cycle sets again
  assign irqSt_d = (rdIrqSt ? 3'h0 : irqSt_q) | irqEv;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqSt_q   <= 3'h0;
      irqMask_q <= `AES_IRQMSK_RST;
      irq_q     <= 1'b0;
    end else begin
      irqSt_q <= irqSt_d;
      if (wrIrqMask) begin
        irqMask_q <= wrData[2:0];
      end
      irq_q <= |(irqSt_d & (wrIrqMask ? wrData[2:0] : irqMask_q));
    end
  end

  // ------------------------------------------------------------
  // count and scroller
  // ------------------------------------------------------------
  aes_counter u_counter (
    .clk     (clk),
    .resetn  (resetn),
    .status  (status_q),
    .count_q (count_q)
  );

  aes_scroller u_scroller (
    .clk          (clk),
    .resetn       (resetn),
    .count        (count_q),
    .up           (keys.scrollUp),
    .down         (keys.scrollDown),
    .pos_q        (scrollPos_q),
    .scrollable_q (scrollable_q)
  );

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // status, count, queue and scroll words are readouts only: no write
  // decode exists for them, so writes there simply fall away
  assign rdMux =
    (addr == `AES_REG_STATUS) ? 32'(status_q) :
    (addr == `AES_REG_COUNT)  ? 32'(count_q) :
    (addr == `AES_REG_LATCH)  ? 32'(latchMask_q) :
    (addr == `AES_REG_ENABLE) ? 32'(enMask_q) :
    (addr == `AES_REG_IRQST)  ? 32'(irqSt_q) :
    (addr == `AES_REG_IRQMSK) ? 32'(irqMask_q) :
    (addr == `AES_REG_QUEUE)  ? {16'h0, `AES_PQ_MAX, pulseQueueOccupancy} :
    (addr == `AES_REG_SCROLL) ? {23'h0, scrollable_q, 4'h0, scrollPos_q} :
                                32'h0;

  // data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 32'h0;
    end else begin
      rdData_q <= rdStb ? rdMux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_disabled_hidden: assert property (
    ##1 (status_q & ~$past(enMask_q)) == '0)
    else $error("disabled event shows in status");

  chk_unlatched_follows: assert property (
    ##1 (status_q & $past(enMask_q) & ~$past(latchMask_q)) == ($past(evtCond) & $past(enMask_q) & ~$past(latchMask_q)))
    else $error("unlatched event does not follow its condition");

  chk_latched_holds: assert property (
    clrState_q != CLR_WIPE && $stable(latchMask_q) ##1 $stable(latchMask_q) && $stable(enMask_q) |->
      (($past(status_q) & latchMask_q & enMask_q) & ~status_q) == '0)
    else $error("latched event dropped without clear");

  chk_clear_ack: assert property (
    clrState_q == CLR_WIPE |=> clrAck_q && status_q == ($past(evtCond) & $past(enMask_q)) ##1 !clrAck_q)
    else $error("clear not carried out then acknowledged");

  chk_nv_save: assert property (
    acceptEv |=> nvWrStb_q && nvWrData_q.latchMask == latchMask_q && nvWrData_q.enMask == enMask_q)
    else $error("accept did not save both masks");

  chk_toggle_one: assert property (
    tglLatch && !wrLatch && !nvLoadStb && tglIdx < 4'hE |=> $countones(latchMask_q ^ $past(latchMask_q)) == 1)
    else $error("toggle did not invert exactly one bit");

  chk_ro_ignore: assert property (
    wrStb && (addr == `AES_REG_COUNT || addr == `AES_REG_QUEUE) && !nvLoadStb && !keys.accept |=>
      $stable(latchMask_q) && $stable(enMask_q) && !nvWrStb_q)
    else $error("write to readout had an effect");

  chk_queue_read: assert property (
    rdStb && addr == `AES_REG_QUEUE |=> rdData_q[15:0] == {`AES_PQ_MAX, $past(pulseQueueOccupancy)})
    else $error("queue readout wrong");

  chk_reset_defaults: assert property (
    $rose(resetn) |-> latchMask_q == 14'h0001 && enMask_q == 14'h0001 && status_q == '0)
    else $error("reset defaults wrong");

  chk_irq_level: assert property (
    ##1 irq_q == |($past(irqSt_d) & irqMask_q))
    else $error("interrupt level wrong");

  // mask port and reload: each guards a path that a run reaches only
  // a few times, so a slip there would otherwise go unseen
  chk_en_toggle: assert property (
    tglEn && !wrEnable && !nvLoadStb && tglIdx < 4'hE |=> $countones(enMask_q ^ $past(enMask_q)) == 1)
    else $error("enable toggle did not invert exactly one bit");

  chk_mask_write: assert property (
    wrLatch && !nvLoadStb |=> 32'(latchMask_q) == ($past(wrData) & 32'h00003FFF))
    else $error("latch mask write lost");

  chk_nv_load: assert property (
    nvLoadStb |=> {latchMask_q, enMask_q} == $past(nvLoadData))
    else $error("mask reload lost");

  // a sticky bit left behind would resurface when latching returns
  chk_sticky_gated: assert property (
    ##1 (sticky_q & ~($past(latchMask_q) & $past(enMask_q))) == '0)
    else $error("sticky bit set for an unlatched or disabled event");

  chk_count_zero: assert property (
    status_q == '0 |=> count_q == 4'h0)
    else $error("count not zero with no active event");

  // interrupt status and read port
  chk_irq_sets: assert property (
    irqEv != 3'h0 |=> (irqSt_q & $past(irqEv)) == $past(irqEv))
    else $error("interrupt event not recorded");

  // a read that meets an event keeps it, so only a quiet read empties
  chk_irq_clears: assert property (
    rdIrqSt && irqEv == 3'h0 |=> irqSt_q == 3'h0)
    else $error("interrupt status not cleared by read");

  chk_read_idle: assert property (
    !rdStb |=> rdData_q == 32'h0)
    else $error("read data outside its cycle");

  cov_clear_seq: cover property (clearReq ##1 clrState_q == CLR_WIPE ##1 clrAck_q);
  cov_latched_evt: cover property ((status_q & latchMask_q) != '0 && (evtCond & latchMask_q) == '0);
  cov_nv_save: cover property (keys.accept ##1 nvWrStb_q);
  cov_nv_reload: cover property (nvLoadStb ##1 latchMask_q != `AES_LATCH_RST);

endmodule : aes_event_status

// >>> bench/aes_nv_model.sv
/*
  Nonvolatile mask memory as the event block sees it: keeps the last saved
  mask image through any reset and hands it back on request.
  Assumes save strobes synchronous to clk; loadReq is a one-cycle pulse.
*/
`include "aes_defines.svh"

module aes_nv_model
  import aes_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    saveStb,
  input  wire aes_nv_t saveData,
  input  wire logic    loadReq,
  output logic         loadStb,
  output aes_nv_t      loadData
);
  timeunit 1ns;
  timeprecision 1ns;

  // no reset on purpose: the image must outlive a power loss
  aes_nv_t store = {`AES_LATCH_RST, `AES_ENABLE_RST};

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // data is inverted while not loading, so a stale image is never mistaken
  always @(posedge clk) begin
    if (saveStb) store <= saveData;
    loadStb <= loadReq;
    loadData <= loadReq ? store : ~store;
  end
endmodule : aes_nv_model

// >>> bench/aes_event_status_bench.sv
/*
  Self-checking bench of the alarm event status block: register port,
  event masks, clear, scroller, interrupt, save and power loss.
  Assumes the design files under core/ and the nv memory model.
*/
`include "aes_defines.svh"

module aes_event_status_bench;
  import aes_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, resetn, wrStb, rdStb, nvLoadStb, nvWrStb_q, clrAck_q, scrollable_q, irq_q, loadReq;
  logic        [7:0]  addr, pqOcc;
  logic        [31:0] wrData, rdData_q;
  aes_evt_t           evtCond, status_q;
  aes_keys_t          keys;
  aes_nv_t            nvLoadData, nvWrData_q;
  logic        [3:0]  count_q, scrollPos_q;
  int                 n_mismatch, comparisons;

  aes_event_status dut (.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData_q(rdData_q), .evtCond(evtCond), .keys(keys),
    .pulseQueueOccupancy(pqOcc), .nvLoadStb(nvLoadStb), .nvLoadData(nvLoadData),
    .nvWrStb_q(nvWrStb_q), .nvWrData_q(nvWrData_q), .status_q(status_q), .count_q(count_q),
    .clrAck_q(clrAck_q), .scrollPos_q(scrollPos_q), .scrollable_q(scrollable_q), .irq_q(irq_q));

  aes_nv_model nvMem (.clk(clk), .saveStb(nvWrStb_q), .saveData(nvWrData_q), .loadReq(loadReq),
    .loadStb(nvLoadStb), .loadData(nvLoadData));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin wrStb <= 1'b1; addr <= a; wrData <= d; end
    @(posedge clk) wrStb <= 1'b0;
  endtask : regWr

  // read data stands only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk) begin rdStb <= 1'b1; addr <= a; end
    @(posedge clk) rdStb <= 1'b0;
    #1 check(rdData_q, exp, what);
  endtask : rdChk

  // status follows one edge later, the count one more
  task automatic setCond(input aes_evt_t v);
    @(posedge clk) evtCond <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask : setCond

  task automatic press(input logic [3:0] k);
    @(posedge clk) keys <= aes_keys_t'(k);
    @(posedge clk) keys <= '0;
  endtask : press

  task automatic waitIrq(input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound && irq_q !== lvl; i++) @(posedge clk) #1;
    check(32'(irq_q), 32'(lvl), "irq level");
    if (irq_q !== lvl) finish_test(); // bound used up ends the run
  endtask : waitIrq

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    check(32'(status_q), 32'h0, "status after reset");
    rdChk(`AES_REG_COUNT, 32'h0, "count idle");
    rdChk(`AES_REG_LATCH, 32'h1, "latch default");
    rdChk(`AES_REG_ENABLE, 32'h1, "enable default");
    rdChk(`AES_REG_QUEUE, {16'h0000, `AES_PQ_MAX, 8'h2A}, "queue readout");
    rdChk(8'h24, 32'h0, "unmapped read");
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_mask_latch();
    setCond(14'h3FFF);
    check(32'(status_q), 32'h1, "disabled events hidden");
    check(32'(count_q), 32'h1, "count one");
    setCond(14'h0000);
    check(32'(status_q), 32'h1, "latched event held");
    regWr(`AES_REG_ENABLE, 32'h3FFF);
    setCond(14'h0004);
    check(32'(status_q), 32'h5, "unlatched shows live");
    setCond(14'h0000);
    check(32'(status_q), 32'h1, "unlatched drops");
    $display("test mask_latch done");
  endtask : t_mask_latch

  // clear by key, then by register; each must wipe and acknowledge once
  task automatic t_clear();
    for (int m = 0; m < 2; m++) begin
      setCond(14'h0001);
      setCond(14'h0000);
      if (m == 0) press(4'h1);
      else regWr(`AES_REG_CTRL, 32'h1);
      @(posedge clk) #1 check(32'(clrAck_q), 32'h1, "clear ack");
      check(32'(status_q), 32'h0, "status wiped");
      @(posedge clk) #1 check(32'(clrAck_q), 32'h0, "ack one cycle");
    end
    $display("test clear done");
  endtask : t_clear

  task automatic t_toggle();
    logic [31:0] en;
    en = 32'h3FFF;
    for (int i = 0; i < 14; i += 3) begin
      regWr(`AES_REG_CTRL, (i << 8) | 32'h8);
      en[i] = ~en[i];
    end
    rdChk(`AES_REG_ENABLE, en, "enable toggles");
    regWr(`AES_REG_CTRL, 32'h0304);
    regWr(`AES_REG_CTRL, 32'h0E04);
    rdChk(`AES_REG_LATCH, 32'h9, "latch toggle");
    regWr(`AES_REG_ENABLE, 32'h3FFF);
    regWr(`AES_REG_LATCH, 32'h0);
    $display("test toggle done");
  endtask : t_toggle

  task automatic t_scroll();
    setCond(14'h3FFF);
    check(32'(count_q), 32'hE, "count all");
    repeat (8) press(4'h4);
    rdChk(`AES_REG_SCROLL, 32'h107, "scroll bottom");
    press(4'h8);
    @(posedge clk) #1 check(32'(scrollPos_q), 32'h6, "scroll up");
    setCond(14'h00FF);
    @(posedge clk) #1 check(32'(scrollPos_q), 32'h1, "scroll pulled back");
    check(32'(scrollable_q), 32'h1, "eight scrollable");
    setCond(14'h007F);
    @(posedge clk) #1 check(32'({scrollable_q, scrollPos_q}), 32'h0, "seven not scrollable");
    $display("test scroll done");
  endtask : t_scroll

  task automatic t_readonly();
    regWr(`AES_REG_STATUS, 32'h0);
    regWr(`AES_REG_COUNT, 32'hF);
    regWr(`AES_REG_QUEUE, 32'h0);
    @(posedge clk) pqOcc <= 8'hC5;
    rdChk(`AES_REG_STATUS, 32'h7F, "status read only");
    rdChk(`AES_REG_QUEUE, {16'h0000, `AES_PQ_MAX, 8'hC5}, "queue read only");
    $display("test readonly done");
  endtask : t_readonly

  task automatic t_irq();
    regWr(`AES_REG_IRQMSK, 32'h1);
    setCond(14'h0000);
    rdChk(`AES_REG_IRQST, 32'h3, "flush pending");
    waitIrq(1'b0, 3);
    setCond(14'h0100);
    waitIrq(1'b1, 4);
    rdChk(`AES_REG_IRQST, 32'h1, "new event flagged");
    waitIrq(1'b0, 3);
    regWr(`AES_REG_IRQMSK, 32'h0);
    setCond(14'h0300);
    repeat (3) @(posedge clk);
    #1 check(32'(irq_q), 32'h0, "masked irq");
    rdChk(`AES_REG_IRQST, 32'h1, "masked still flagged");
    $display("test irq done");
  endtask : t_irq

  // save, lose power, then reload from the memory
  task automatic t_save_power();
    setCond(14'h0000);
    regWr(`AES_REG_LATCH, 32'h5);
    regWr(`AES_REG_ENABLE, 32'h7);
    press(4'h2);
    #1 check(32'(nvWrStb_q), 32'h1, "key save strobe");
    check(32'(nvWrData_q), {4'h0, 14'h0005, 14'h0007}, "saved image");
    regWr(`AES_REG_CTRL, 32'h2);
    #1 check(32'(nvWrStb_q), 32'h1, "register save strobe");
    setCond(14'h0001);
    setCond(14'h0000);
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk) #1 check(32'(status_q), 32'h0, "status lost");
    @(posedge clk) loadReq <= 1'b1;
    @(posedge clk) loadReq <= 1'b0;
    repeat (2) @(posedge clk);
    rdChk(`AES_REG_LATCH, 32'h5, "latch restored");
    rdChk(`AES_REG_ENABLE, 32'h7, "enable restored");
    check(32'(status_q), 32'h0, "status stays clear");
    $display("test save_power done");
  endtask : t_save_power

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t run timed out", $time);
    finish_test();
  end

  initial begin
    {resetn, wrStb, rdStb, loadReq, addr, wrData} = '0;
    evtCond = '0;
    pqOcc = 8'h2A;
    keys = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk) #1;
    t_defaults();
    t_mask_latch();
    t_clear();
    t_toggle();
    t_scroll();
    t_readonly();
    t_irq();
    t_save_power();
    finish_test();
  end
endmodule : aes_event_status_bench
